//--- serial_port_pkg.sv
// constants, register layout and state record of the serial port
package serial_port_pkg;

	// register word indices; byte address is four times the index
	localparam logic [5:0] IDX_DATA = 6'h05;
	localparam logic [5:0] IDX_CTRL = 6'h14;
	localparam logic [5:0] IDX_STAT = 6'h15;

	// main control field positions
	localparam int B_IRQ_EN  = 7;
	localparam int B_OUT_EN  = 6;
	localparam int B_HALVER  = 5;
	localparam int B_MASTER  = 4;
	localparam int B_IDLE_LV = 3;
	localparam int B_PHASE   = 2;
	localparam int B_RATE_HI = 1;
	localparam int B_RATE_LO = 0;

	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;

	// edge count of the last serial clock transition of a byte
	localparam logic [3:0] LAST_EDGE = 4'hf;

	// serial engine states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_MSHIFT = 3'b010,
		ST_SSEL   = 3'b100
	} st_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic       out_off;
		logic       sel_ovr;
		logic       sel_lvl;
		logic       done_f;
		logic       coll_f;
		logic       ovr_f;
		logic       fault_f;
		logic       done_arm;
		logic       ovr_arm;
		logic       fault_arm;
		logic       coll_arm;
		st_t        st;
		logic [5:0] div;
		logic [3:0] ecnt;
		logic [7:0] shreg;
		logic [7:0] rx_buf;
		logic       out_bit;
		logic       sck;
		logic       ss_s1;
		logic       ss_s2;
		logic       sck_s1;
		logic       sck_s2;
		logic       sck_s3;
		logic       mosi_s1;
		logic       mosi_s2;
		logic       miso_s1;
		logic       miso_s2;
		logic       ack;
		logic [7:0] dat;
		logic       irq;
		logic       sck_oe;
		logic       mosi_oe;
		logic       miso_oe;
	} state_t;

endpackage : serial_port_pkg

//--- serial_port.sv
// byte-wide serial peripheral port with classic wishbone register slave
//
// What this block does
// - phase bit 0 captures on first clock transition, 1 on second.
// - master clock is system clock over 2,4,8,16,32,64 per rate bits.
// - low rate bits do nothing in slave mode.
// - done flag bit 7 sets at each byte end, interrupt if enabled.
// - done flag clears after status access then data read or write.
// - data writes are ignored while the done flag is set.
// - collision flag bit 6 sets on data write during shifting.
// - overrun bit 5 sets when byte ends with done flag still set.
// - overrun clears after status read then data read or write.
// - fault bit 4 sets when select goes low in master mode.
// - fault clears after status access while set, then control write.
// - status bit 2 releases the serial data output.
// - status bit 1 ignores the select pin, uses internal select bit.
// - internal select bit is active low when override is on.
// - received byte copied to buffer at byte end unless done is still set; reads return buffer.
// - master transfer starts only on a data register write.
// - data write loads the shift register directly.
// - collision flag raises no interrupt.
// - fault clears output enable and master select.
// - idle clock level follows the idle level bit.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps

module serial_port (
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic        SCK_I,
	output logic             SCK_O,
	output logic             SCK_OE,
	input  wire logic        MOSI_I,
	output logic             MOSI_O,
	output logic             MOSI_OE,
	input  wire logic        MISO_I,
	output logic             MISO_O,
	output logic             MISO_OE,
	input  wire logic        SS_N_I,
	output logic             IRQ_O
);

	////////////////////////////////////////////////////////////////////////////
	// rate decode

	// half period in system clocks; the halver bit doubles the rate
	function automatic logic [5:0] half_cycles(input logic [2:0] rate);
		case (rate)
			3'b100:  half_cycles = 6'h01;
			3'b000:  half_cycles = 6'h02;
			3'b101:  half_cycles = 6'h02;
			3'b001:  half_cycles = 6'h04;
			3'b110:  half_cycles = 6'h08;
			3'b010:  half_cycles = 6'h10;
			3'b111:  half_cycles = 6'h10;
			3'b011:  half_cycles = 6'h20;
			default: half_cycles = 6'h02;
		endcase
	endfunction : half_cycles

	serial_port_pkg::state_t r;
	serial_port_pkg::state_t n;

	logic       acc;
	logic       wr;
	logic       rd;
	logic [5:0] idx;
	logic       tx_wr;
	logic       rx_rd;
	logic       stat_acc;
	logic       stat_rd;
	logic       ctrl_wr;
	logic       ss_low;
	logic       clock_phase_sel;
	logic [5:0] half;
	logic       m_edge;
	logic       s_act;
	logic       s_edge;
	logic       sh_edge;
	logic       capture;
	logic       launch;
	logic       in_bit;
	logic       done;
	logic       busy;
	logic       tx_load;
	logic [7:0] rx_byte;
	logic [7:0] stat_val;

	////////////////////////////////////////////////////////////////////////////
	// bus decode; one wait state, ack drops the cycle after
	assign acc      = WB_CYC_I & WB_STB_I & ~r.ack;
	assign wr       = acc & WB_WE_I & WB_SEL_I[0];
	assign rd       = acc & ~WB_WE_I;
	assign idx      = WB_ADR_I[7:2];
	assign tx_wr    = wr & (idx == serial_port_pkg::IDX_DATA);
	assign rx_rd    = rd & (idx == serial_port_pkg::IDX_DATA);
	assign stat_acc = acc & (idx == serial_port_pkg::IDX_STAT);
	assign stat_rd  = stat_acc & ~WB_WE_I;
	assign ctrl_wr  = wr & (idx == serial_port_pkg::IDX_CTRL);
	assign stat_val = {r.done_f, r.coll_f, r.ovr_f, r.fault_f, 1'b0,
		r.out_off, r.sel_ovr, r.sel_lvl};

	////////////////////////////////////////////////////////////////////////////
	// serial timing terms

	assign ss_low  = r.sel_ovr ? ~r.sel_lvl : ~r.ss_s2;
	assign clock_phase_sel    = r.ctrl[serial_port_pkg::B_PHASE];
	assign half    = half_cycles({r.ctrl[serial_port_pkg::B_HALVER],
		r.ctrl[serial_port_pkg::B_RATE_HI], r.ctrl[serial_port_pkg::B_RATE_LO]});
	assign m_edge  = (r.st == serial_port_pkg::ST_MSHIFT) && (r.div == half - 6'h01);
	assign s_act   = r.ctrl[serial_port_pkg::B_OUT_EN] & ~r.ctrl[serial_port_pkg::B_MASTER]
		& ss_low;
	// synced clock edge; the first sync stage is read by nothing else
	assign s_edge  = (r.st == serial_port_pkg::ST_SSEL) && s_act && (r.sck_s2 ^ r.sck_s3);
	assign sh_edge = m_edge | s_edge;
	// capture on odd or even edges
	assign capture = sh_edge & (r.ecnt[0] == clock_phase_sel);
	assign launch  = sh_edge & (r.ecnt[0] != clock_phase_sel);
	assign in_bit  = r.ctrl[serial_port_pkg::B_MASTER] ? r.miso_s2 : r.mosi_s2;
	assign done    = sh_edge & (r.ecnt == serial_port_pkg::LAST_EDGE);
	assign rx_byte = capture ? {r.shreg[6:0], in_bit} : r.shreg;
	// slave with phase 0 is busy from select, since the first edge may come anytime
	assign busy    = (r.st == serial_port_pkg::ST_MSHIFT)
		| ((r.st == serial_port_pkg::ST_SSEL) & ((r.ecnt != 4'h0) | ~clock_phase_sel));
	assign tx_load = tx_wr & ~r.done_f & ~busy;

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		n = r;
		// synchronisers for pins
		n.ss_s1   = SS_N_I;
		n.ss_s2   = r.ss_s1;
		n.sck_s1  = SCK_I;
		n.sck_s2  = r.sck_s1;
		n.sck_s3  = r.sck_s2;
		n.mosi_s1 = MOSI_I;
		n.mosi_s2 = r.mosi_s1;
		n.miso_s1 = MISO_I;
		n.miso_s2 = r.miso_s1;

		// bus answer
		n.ack = acc;
		n.dat = 8'h00;
		if (rd) begin
			case (idx)
				serial_port_pkg::IDX_DATA: n.dat = r.rx_buf;
				serial_port_pkg::IDX_CTRL: n.dat = r.ctrl;
				serial_port_pkg::IDX_STAT: n.dat = stat_val;
				default:                   n.dat = 8'h00;
			endcase
		end

		// register writes
		if (ctrl_wr) begin
			n.ctrl = WB_DAT_I[7:0];
			// enable and master stay off while a fault is pending, unless clearing
			if (r.fault_f & ~r.fault_arm) begin
				n.ctrl[serial_port_pkg::B_OUT_EN] = 1'b0;
				n.ctrl[serial_port_pkg::B_MASTER] = 1'b0;
			end
		end
		if (stat_acc & WB_WE_I & WB_SEL_I[0]) begin
			n.out_off = WB_DAT_I[2];
			n.sel_ovr = WB_DAT_I[1];
			n.sel_lvl = WB_DAT_I[0];
		end

		// serial engine
		case (r.st)
			serial_port_pkg::ST_IDLE: begin
				n.sck  = r.ctrl[serial_port_pkg::B_IDLE_LV];
				n.div  = 6'h00;
				n.ecnt = 4'h0;
				if (tx_load & r.ctrl[serial_port_pkg::B_MASTER]
					& r.ctrl[serial_port_pkg::B_OUT_EN]) begin
					n.st = serial_port_pkg::ST_MSHIFT;
				end else if (s_act) begin
					n.st = serial_port_pkg::ST_SSEL;
				end
			end
			serial_port_pkg::ST_MSHIFT: begin
				n.div = r.div + 6'h01;
				if (m_edge) begin
					n.div  = 6'h00;
					n.sck  = ~r.sck;
					n.ecnt = r.ecnt + 4'h1;
					if (done) begin
						n.st = serial_port_pkg::ST_IDLE;
					end
				end
			end
			serial_port_pkg::ST_SSEL: begin
				if (!s_act) begin
					n.st   = serial_port_pkg::ST_IDLE;
					n.ecnt = 4'h0;
				end else if (s_edge) begin
					n.ecnt = r.ecnt + 4'h1;
				end
			end
			default: n.st = serial_port_pkg::ST_IDLE;
		endcase

		// msb first, in and out together
		if (capture) begin
			n.shreg = {r.shreg[6:0], in_bit};
		end
		if (launch) begin
			n.out_bit = r.shreg[7];
		end
		if (tx_load) begin
			n.shreg   = WB_DAT_I[7:0];
			n.out_bit = WB_DAT_I[7];
		end

		// arming steps of the clearing sequences
		if (stat_acc & r.done_f) n.done_arm = 1'b1;
		if (stat_rd & r.ovr_f) n.ovr_arm = 1'b1;
		if (stat_acc & r.fault_f) n.fault_arm = 1'b1;
		if (stat_rd & r.coll_f) n.coll_arm = 1'b1;
		if (r.done_arm & (rx_rd | tx_wr)) begin
			n.done_f   = 1'b0;
			n.done_arm = 1'b0;
		end
		if (r.ovr_arm & (rx_rd | tx_wr)) begin
			n.ovr_f   = 1'b0;
			n.ovr_arm = 1'b0;
		end
		// collision clears only by a data read, a write would be a new collision
		if (r.coll_arm & rx_rd) begin
			n.coll_f   = 1'b0;
			n.coll_arm = 1'b0;
		end
		if (r.fault_arm & ctrl_wr) begin
			n.fault_f   = 1'b0;
			n.fault_arm = 1'b0;
		end

		// sets come last so that they win over clears
		// done at byte end
		if (done) begin
			if (r.done_f) begin
				n.ovr_f = 1'b1;
			end else begin
				n.rx_buf = rx_byte;
			end
			n.done_f = 1'b1;
		end
		if (tx_wr & busy) begin
			n.coll_f = 1'b1;
		end
		if (r.ctrl[serial_port_pkg::B_MASTER] & ss_low) begin
			n.fault_f = 1'b1;
			n.ctrl[serial_port_pkg::B_OUT_EN] = 1'b0;
			n.ctrl[serial_port_pkg::B_MASTER] = 1'b0;
			n.st = serial_port_pkg::ST_IDLE;
		end

		n.irq     = n.ctrl[serial_port_pkg::B_IRQ_EN] & (n.done_f | n.ovr_f | n.fault_f);
		n.sck_oe  = n.ctrl[serial_port_pkg::B_OUT_EN] & n.ctrl[serial_port_pkg::B_MASTER];
		n.mosi_oe = n.sck_oe & ~n.out_off;
		n.miso_oe = n.ctrl[serial_port_pkg::B_OUT_EN] & ~n.ctrl[serial_port_pkg::B_MASTER]
			& ~n.out_off & s_act;
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			r        <= '0;
			r.ctrl   <= serial_port_pkg::CTRL_RST;
			r.rx_buf <= serial_port_pkg::DATA_RST;
			r.st     <= serial_port_pkg::ST_IDLE;
			r.ss_s1  <= 1'b1;
			r.ss_s2  <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// outputs straight from the state record
	assign WB_DAT_O = {24'h000000, r.dat};
	assign WB_ACK_O = r.ack;
	assign SCK_O    = r.sck;
	assign SCK_OE   = r.sck_oe;
	assign MOSI_O   = r.out_bit;
	assign MOSI_OE  = r.mosi_oe;
	assign MISO_O   = r.out_bit;
	assign MISO_OE  = r.miso_oe;
	assign IRQ_O    = r.irq;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	sequence status_touch;
		stat_acc & r.done_f;
	endsequence
	sequence data_step;
		r.done_arm & (rx_rd | tx_wr) & !done;
	endsequence

	bus_ack_a: assert property (WB_CYC_I & WB_STB_I & !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
		else $error("ack not a one cycle answer");
	rate_edge_a: assert property (m_edge |=> (SCK_O != $past(SCK_O)) && (r.div == 6'h00))
		else $error("master clock edge spacing wrong");
	done_set_a: assert property (done |=> r.done_f && (IRQ_O
		|| !r.ctrl[serial_port_pkg::B_IRQ_EN]))
		else $error("done flag or request missing");
	done_clr_a: assert property (status_touch ##[1:8] data_step
		|=> !r.done_f)
		else $error("done flag survives clearing sequence");
	tx_block_a: assert property (tx_wr & r.done_f & !capture |=> $stable(r.shreg))
		else $error("data write taken while done flag set");
	// a capture edge in the same cycle still moves the shifter, the write must not
	collide_a: assert property (tx_wr & busy
		|=> r.coll_f && ($past(capture) || $stable(r.shreg)))
		else $error("collision not flagged");
	overrun_a: assert property (done & r.done_f |=> r.ovr_f && $stable(r.rx_buf))
		else $error("overrun not flagged or buffer overwritten");
	fault_a: assert property (r.ctrl[serial_port_pkg::B_MASTER] & ss_low
		|=> r.fault_f && !r.ctrl[serial_port_pkg::B_OUT_EN] && !SCK_OE)
		else $error("mode fault handling wrong");
	idle_lvl_a: assert property ((r.st == serial_port_pkg::ST_IDLE)[*2]
		|-> SCK_O == $past(r.ctrl[serial_port_pkg::B_IDLE_LV]))
		else $error("idle clock level wrong");
	out_off_a: assert property (r.out_off |-> !MOSI_OE && !MISO_OE)
		else $error("data output not released");
	stat_bit3_a: assert property (stat_rd |=> WB_DAT_O[3] == 1'b0)
		else $error("unused status bit not zero");
	rx_buf_a: assert property (done & !r.done_f |=> r.rx_buf == $past(rx_byte))
		else $error("received byte not buffered");

endmodule : serial_port

//--- far_slave.sv
// behavioural far-side partners of the serial port: a phase 0 slave and a phase 1 master
`timescale 1ns/1ps

module far_slave (
	input  wire logic       sck,
	input  wire logic       sel_n,
	input  wire logic       mosi,
	input  wire logic [7:0] tx,
	output logic            miso,
	output logic [7:0]      rx
);
	logic [7:0] sh = 8'h00;
	initial miso = 1'b0;
	// first bit waits on the line from select onward
	always @(negedge sel_n) begin
		sh = tx;
		miso = tx[7];
	end
	always @(posedge sck) if (!sel_n) begin
		sh = {sh[6:0], mosi};
		rx = sh;
	end
	always @(negedge sck) if (!sel_n) miso = sh[7];
	// released line flips so stale data cannot pass for a match
	always @(posedge sel_n) miso = ~miso;
endmodule : far_slave

////////////////////////////////////////////////////////////////////////////////

// far master clocking the port while it is a slave; clock stands still between bytes
module far_master (
	input  wire logic clk,
	output logic      sck,
	output logic      mosi
);
	initial sck = 1'b0;
	initial mosi = 1'b0;
	// phase 1: bit launched on odd edges, captured on even ones
	// idle low; slow edges leave room for the port's pin synchronisers
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 16; i++) begin
			repeat (8) @(posedge clk);
			sck <= ~sck;
			if (i[0] == 1'b0) mosi <= b[7 - i / 2];
		end
		repeat (8) @(posedge clk);
	endtask : send
endmodule : far_master

//--- serial_port_tb_top.sv
// register-level testbench of the serial port with a far slave
`timescale 1ns/1ps

module serial_port_tb_top;
	logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ss_pin = 1, sel_n = 1;
	logic [7:0]  adr = 8'h00, q, f, far_tx = 8'h00, far_rx;
	logic [31:0] wdat = 32'h0, rdat;
	logic        ack, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq, miso_far;
	logic        slv = 0, m_sck, m_mosi;
	int          errors = 0, total_checks = 0, n;
	// half period per rate code {halver, rate_hi, rate_lo}
	int          hh [8] = '{2, 4, 16, 32, 1, 2, 8, 16};

	always #50 clk = ~clk;

	serial_port DUT (.SYS_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .SCK_I(slv ? m_sck : sck_o), .SCK_O(sck_o),
		.SCK_OE(sck_oe), .MOSI_I(slv ? m_mosi : mosi_o), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe),
		.MISO_I(miso_far), .MISO_O(miso_o), .MISO_OE(miso_oe), .SS_N_I(ss_pin),
		.IRQ_O(irq));

	far_slave FAR (.sck(sck_o), .sel_n(sel_n), .mosi(mosi_o), .tx(far_tx),
		.miso(miso_far), .rx(far_rx));

	// drives clock and data in only while the port is tested as a slave
	far_master FARM (.clk(clk), .sck(m_sck), .mosi(m_mosi));

	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one classic cycle; request held until ack is seen, then released
	task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk);
		cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= {24'h0, d};
		// ack and read data are both taken at the rising edge that shows ack high
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (ack !== 1'b1) chk("bus ack", 8'h01, 8'h00);
		q = rdat[7:0];
		cyc <= 0; stb <= 0; we <= 0;
	endtask : bus

	// status polling doubles as the first step of every clearing sequence
	task wait_done;
		int k;
		k = 0;
		f = 8'h00;
		while (f[7] !== 1'b1 && k < 300) begin
			bus(8'h54, 1'b0, 8'h00);
			f = q;
			k++;
		end
		// a byte that never ends is a mismatch of its own
		if (f[7] !== 1'b1) chk("done wait", 8'h80, f);
	endtask : wait_done

	// watchdog, far beyond the longest expected run
	initial begin
		#3ms;
		errors++;
		end_of_test();
	end

	initial begin
		repeat (2) @(posedge clk);
		rst <= 0;
		bus(8'h54, 0, 0); chk("flags reset", 8'h00, q);
		bus(8'h50, 0, 0); chk("ctrl reset", 8'h00, q);
		bus(8'h14, 0, 0); chk("rx reset", 8'h00, q);
		bus(8'h54, 1, 8'h08); bus(8'h54, 0, 0); chk("unused bit", 8'h00, q);
		bus(8'h7c, 1, 8'hff); bus(8'h7c, 0, 0); chk("unmapped", 8'h00, q);
		$display("test reset values done");
		// flags written before control
		bus(8'h54, 1, 8'h00);
		bus(8'h50, 1, 8'hd1); bus(8'h50, 0, 0); chk("ctrl", 8'hd1, q);
		far_tx <= 8'h3c; sel_n <= 0;
		bus(8'h14, 1, 8'ha5);
		wait_done(); chk("done flag", 8'h80, f);
		chk("irq on done", 8'h01, {7'h0, irq});
		bus(8'h14, 0, 0); chk("rx byte", 8'h3c, q);
		chk("far rx", 8'ha5, far_rx);
		bus(8'h54, 0, 0); chk("done cleared", 8'h00, q);
		chk("irq cleared", 8'h00, {7'h0, irq});
		sel_n <= 1;
		$display("test master transfer done");
		bus(8'h14, 1, 8'h5a); bus(8'h14, 1, 8'h00);
		chk("no collision irq", 8'h00, {7'h0, irq});
		wait_done(); chk("collision", 8'hc0, f);
		// clearing write while done is set must not start a byte
		bus(8'h14, 1, 8'h66);
		n = 0;
		repeat (20) begin
			@(negedge clk);
			if (sck_o !== 1'b0) n++;
		end
		chk("no shift", 8'h00, 8'(n));
		bus(8'h54, 0, 0); chk("collision kept", 8'h40, q);
		bus(8'h14, 0, 0); bus(8'h54, 0, 0); chk("collision cleared", 8'h00, q);
		$display("test collision done");
		bus(8'h54, 1, 8'h04); @(negedge clk); chk("out off", 8'h00, {7'h0, mosi_oe});
		bus(8'h54, 1, 8'h00); @(negedge clk); chk("out on", 8'h01, {7'h0, mosi_oe});
		$display("test output disable done");
		for (int i = 0; i < 8; i++) begin
			bus(8'h50, 1, 8'h50 | {2'b0, 1'(i >> 2), 3'b0, 2'(i)});
			bus(8'h14, 1, 8'h00);
			n = 0;
			while (sck_o !== 1'b1 && n < 100) begin
				@(negedge clk);
				n++;
			end
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (sck_o === 1'b1 && n < 100);
			chk("half period", 8'(hh[i]), 8'(n));
			wait_done();
			bus(8'h14, 0, 0);
		end
		$display("test rates done");
		bus(8'h50, 1, 8'hd1); ss_pin <= 0; repeat (4) @(posedge clk);
		bus(8'h54, 0, 0); chk("fault flag", 8'h10, q);
		bus(8'h50, 0, 0); chk("ctrl on fault", 8'h81, q);
		chk("fault irq", 8'h01, {7'h0, irq});
		ss_pin <= 1; bus(8'h50, 1, 8'h01);
		bus(8'h54, 0, 0); chk("fault cleared", 8'h00, q);
		bus(8'h54, 1, 8'h03); bus(8'h50, 1, 8'h51); ss_pin <= 0; repeat (4) @(posedge clk);
		bus(8'h54, 0, 0); chk("pin ignored", 8'h03, q);
		bus(8'h54, 1, 8'h02); repeat (4) @(posedge clk);
		bus(8'h54, 0, 0); chk("internal select", 8'h12, q);
		$display("test fault and override done");
		// slave at phase 1 with odd rate bits; this control write also clears the fault
		slv <= 1;
		bus(8'h50, 1, 8'hc7);
		@(negedge clk); chk("slave out on", 8'h01, {7'h0, miso_oe});
		FARM.send(8'h96);
		chk("slave irq", 8'h01, {7'h0, irq});
		// second byte lands while done is still set
		FARM.send(8'h69);
		bus(8'h54, 0, 0); chk("overrun flags", 8'ha2, q);
		bus(8'h14, 0, 0); chk("older byte kept", 8'h96, q);
		bus(8'h54, 0, 0); chk("overrun cleared", 8'h02, q);
		chk("irq after clear", 8'h00, {7'h0, irq});
		$display("test slave overrun done");
		end_of_test();
	end
endmodule : serial_port_tb_top
